/* sac_pkg.sv */
// Purpose: shared constants and types for the converter control unit
// Assumes: one 100 MHz clock, registers reached over a plain strobe port
// Notes: oscillator clock arrives as a one-cycle enable pulse
package sac_pkg;
  localparam logic [7:0] ADDR_STATUS_CONTROL = 8'h38;
  localparam logic [7:0] ADDR_RESULT = 8'h39;
  localparam logic [7:0] ADDR_CLOCK_CONFIG = 8'h3a;
  localparam int DONE_BIT = 7;
  localparam int IRQ_EN_BIT = 6;
  localparam int CONT_BIT = 5;
  localparam int SRC_BIT = 7;
  localparam logic [4:0] CHAN_RESET = 5'h1f;
  localparam logic [4:0] CHAN_OFF = 5'h1f;
  localparam logic [4:0] CHAN_REF_HIGH = 5'h1d;
  localparam logic [4:0] CHAN_REF_LOW = 5'h1e;
  localparam logic [4:0] CHAN_LAST_PORT = 5'h0e;
  localparam logic [4:0] CHAN_PORTD_FIRST = 5'h08;
  localparam logic [2:0] PRESC_RESET = 3'h0;
  localparam logic SRC_RESET = 1'b0;
  localparam logic [4:0] CONV_STEPS = 5'h10;
  localparam logic [7:0] RESULT_FULL = 8'hff;
  localparam logic [7:0] RESULT_ZERO = 8'h00;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sac_bus_t;

  typedef enum logic [1:0] {
    SAC_IDLE = 2'b00,
    SAC_SYNC = 2'b01,
    SAC_CONV = 2'b10
  } sac_state_t;
endpackage

/* sac_control.sv */
// Purpose: digital control of an 8-bit successive-approximation converter
// Assumes: comparator output supplied by the analog macro each step
// Notes: port pin override drives direction and read-mux for ports b and d
// Functional notes
// - pin in use by converter reads zero if direction zero, else data latch.
// - high reference gives ff, low reference gives 00, linear between.
// - status/control write starts conversion, done after 16 to 17 converter clocks.
// - result loaded every completion, overwritten in continuous mode.
// - continuous bit restarts conversion after each completion until cleared.
// - continuous bit clear gives exactly one conversion per start.
// - in continuous mode done flag stays set until write or result read.
// - irq enable zero: done flag read-only, set on completion, cleared by access.
// - irq enable set raises a request at every conversion end.
// - irq enable set makes done bit writable as a service select.
// - pending request cleared on result read or status/control write.
// - reset clears done, irq enable and continuous bits.
// - channel codes 0-7 pick port b, 8-14 pick port d.
// - 1d converts high reference, 1e low reference, others unknown.
// - channel all ones powers down; reset loads all ones.
// - stop aborts conversion and idles; stays idle after stop exits until a status/control write.
// - wait mode keeps running; enabled request can wake processor.
// - prescaler 000 /1, 001 /2, 011 /8, 1xx /16.
// - source bit one selects bus clock, zero oscillator; reset selects oscillator.
// - selected pin forced to input, port writes ignored for it.
//
// Our own choice: the plain strobed port.
module sac_control
  import sac_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire sac_bus_t bus,
  output logic [7:0] rdata,
  input wire logic osc_clk_en,
  input wire logic stop_mode,
  input wire logic wait_mode,
  input wire logic cmp_high,
  output logic [7:0] dac_code_q,
  output logic [4:0] mux_select_q,
  output logic analog_power_q,
  output logic irq_q,
  output logic wake_q,
  input wire logic [7:0] portb_ddr,
  input wire logic [7:0] portb_latch,
  input wire logic [7:0] portb_pin,
  input wire logic [6:0] portd_ddr,
  input wire logic [6:0] portd_latch,
  input wire logic [6:0] portd_pin,
  output logic [7:0] portb_read_q,
  output logic [6:0] portd_read_q,
  output logic [14:0] pin_input_force_q
);
  // ==========================================
  // helpers
  function automatic logic [14:0] chan_onehot(input logic [4:0] ch);
    logic [14:0] v;
    v = 15'h0000;
    if (ch <= CHAN_LAST_PORT)
      v[ch[3:0]] = 1'b1;
    return v;
  endfunction

  function automatic logic [4:0] presc_limit(input logic [2:0] p);
    logic [4:0] v;
    v = 5'h00;
    if (p[2])
      v = 5'h0f;
    else
      unique case (p[1:0])
        2'b00: v = 5'h00;
        2'b01: v = 5'h01;
        2'b10: v = 5'h03;
        2'b11: v = 5'h07;
      endcase
    return v;
  endfunction

  // ==========================================
  // registers
  logic done_q, irq_en_q, cont_q, src_q;
  logic [4:0] chan_q;
  logic [2:0] presc_q;
  logic [7:0] result_q;
  logic wr_sc, rd_res, complete;
  sac_state_t state_q;
  logic [4:0] div_q, step_q;
  logic conv_tick;

  assign wr_sc = bus.wr && bus.addr == ADDR_STATUS_CONTROL;
  assign rd_res = bus.rd && bus.addr == ADDR_RESULT;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      irq_en_q <= 1'b0;
      cont_q <= 1'b0;
      chan_q <= CHAN_RESET;
    end
    else if (wr_sc)
    begin
      irq_en_q <= bus.wdata[IRQ_EN_BIT];
      cont_q <= bus.wdata[CONT_BIT];
      chan_q <= bus.wdata[4:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      src_q <= SRC_RESET;
      presc_q <= PRESC_RESET;
    end
    else if (bus.wr && bus.addr == ADDR_CLOCK_CONFIG)
    begin
      src_q <= bus.wdata[SRC_BIT];
      presc_q <= bus.wdata[6:4];
    end
  end

  // completion set wins over a same-cycle clear
  always_ff @(posedge clk)
  begin
    if (reset)
      done_q <= 1'b0;
    else if (complete && !irq_en_q)
      done_q <= 1'b1;
    else if (wr_sc)
      done_q <= bus.wdata[IRQ_EN_BIT] ? bus.wdata[DONE_BIT] : 1'b0;
    else if (rd_res && !irq_en_q)
      done_q <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      irq_q <= 1'b0;
    else if (complete && irq_en_q)
      irq_q <= 1'b1;
    else if (wr_sc || rd_res)
      irq_q <= 1'b0;
  end

  // request reaches the wake logic during wait
  always_ff @(posedge clk)
  begin
    if (reset)
      wake_q <= 1'b0;
    else
      wake_q <= wait_mode && complete && irq_en_q;
  end

  // ==========================================
  // converter clock divider
  always_ff @(posedge clk)
  begin
    if (reset || stop_mode)
    begin
      div_q <= 5'h00;
      conv_tick <= 1'b0;
    end
    else if (src_q || osc_clk_en)
    begin
      if (div_q >= presc_limit(presc_q))
      begin
        div_q <= 5'h00;
        conv_tick <= 1'b1;
      end
      else
      begin
        div_q <= div_q + 5'h01;
        conv_tick <= 1'b0;
      end
    end
    else
      conv_tick <= 1'b0;
  end

  // ==========================================
  // conversion sequencer: one sync tick then 16 steps
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_q <= SAC_IDLE;
      step_q <= 5'h00;
      dac_code_q <= RESULT_ZERO;
      result_q <= RESULT_ZERO;
      complete <= 1'b0;
    end
    else
    begin
      complete <= 1'b0;
      if (stop_mode)
        state_q <= SAC_IDLE;
      else if (wr_sc)
      begin
        // new channel decides: the old one may still be the off code
        state_q <= bus.wdata[4:0] != CHAN_OFF ? SAC_SYNC : SAC_IDLE;
        step_q <= 5'h00;
      end
      else if (chan_q == CHAN_OFF)
        state_q <= SAC_IDLE;
      else
        unique case (state_q)
          SAC_IDLE: ;
          SAC_SYNC:
            if (conv_tick)
            begin
              state_q <= SAC_CONV;
              step_q <= 5'h00;
              dac_code_q <= 8'h80;
            end
          SAC_CONV:
            if (conv_tick)
            begin
              if (step_q[0] == 1'b0)
                step_q <= step_q + 5'h01;
              else
              begin
                // odd step resolves one bit, sixteen steps total
                if (!cmp_high)
                  dac_code_q[3'(7 - step_q[3:1])] <= 1'b0;
                if (step_q[3:1] != 3'h7)
                  dac_code_q[3'(6 - step_q[3:1])] <= 1'b1;
                step_q <= step_q + 5'h01;
                if (step_q == CONV_STEPS - 5'h01)
                begin
                  result_q <= cmp_high ? dac_code_q : {dac_code_q[7:1], 1'b0};
                  complete <= 1'b1;
                  state_q <= cont_q ? SAC_SYNC : SAC_IDLE;
                end
              end
            end
          default: state_q <= SAC_IDLE;
        endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      mux_select_q <= CHAN_RESET;
      analog_power_q <= 1'b0;
    end
    else
    begin
      mux_select_q <= chan_q;
      analog_power_q <= chan_q != CHAN_OFF && !stop_mode;
    end
  end

  // ==========================================
  // port override
  logic [14:0] sel;
  assign sel = chan_onehot(chan_q);

  genvar gi;
  generate
    for (gi = 0; gi < 15; gi++)
    begin : g_pin
      logic rv;
      if (gi < 8)
        assign rv = sel[gi] ? (portb_ddr[gi] ? portb_latch[gi] : 1'b0)
                            : (portb_ddr[gi] ? portb_latch[gi] : portb_pin[gi]);
      else
        assign rv = sel[gi] ? (portd_ddr[gi-8] ? portd_latch[gi-8] : 1'b0)
                            : (portd_ddr[gi-8] ? portd_latch[gi-8] : portd_pin[gi-8]);
      always_ff @(posedge clk)
      begin
        if (reset)
          pin_input_force_q[gi] <= 1'b0;
        else
          pin_input_force_q[gi] <= sel[gi];
      end
      if (gi < 8)
      begin : g_b
        always_ff @(posedge clk)
        begin
          if (reset)
            portb_read_q[gi] <= 1'b0;
          else
            portb_read_q[gi] <= rv;
        end
      end
      else
      begin : g_d
        always_ff @(posedge clk)
        begin
          if (reset)
            portd_read_q[gi-8] <= 1'b0;
          else
            portd_read_q[gi-8] <= rv;
        end
      end
    end
  endgenerate

  // ==========================================
  // read port
  always_ff @(posedge clk)
  begin
    if (reset)
      rdata <= 8'h00;
    else if (bus.rd)
      unique case (bus.addr)
        ADDR_STATUS_CONTROL: rdata <= {done_q, irq_en_q, cont_q, chan_q};
        ADDR_RESULT: rdata <= result_q;
        ADDR_CLOCK_CONFIG: rdata <= {src_q, presc_q, 4'h0};
        default: rdata <= 8'h00;
      endcase
    else
      rdata <= 8'h00;
  end

  // ==========================================
  // checks
  chk_irq_clear_access: assert property (@(posedge clk) disable iff (reset)
    (wr_sc || rd_res) && !(complete && irq_en_q) |=> !irq_q)
    else $error("request not cleared by access");
  chk_irq_on_done: assert property (@(posedge clk) disable iff (reset)
    complete && irq_en_q |=> irq_q)
    else $error("no request after conversion");
  chk_done_set: assert property (@(posedge clk) disable iff (reset)
    complete && !irq_en_q |=> done_q)
    else $error("done flag not set");
  chk_stop_abort: assert property (@(posedge clk) disable iff (reset)
    stop_mode |=> state_q == SAC_IDLE)
    else $error("conversion not aborted on stop");
  chk_single_idle: assert property (@(posedge clk) disable iff (reset)
    complete && !cont_q && !$past(wr_sc) |-> state_q == SAC_IDLE)
    else $error("single mode kept converting");
  chk_cont_restart: assert property (@(posedge clk) disable iff (reset)
    complete && cont_q && !stop_mode && chan_q != CHAN_OFF && !$past(wr_sc) |-> state_q == SAC_SYNC)
    else $error("continuous mode did not restart");
  chk_off_idle: assert property (@(posedge clk) disable iff (reset)
    chan_q == CHAN_OFF && !wr_sc |=> state_q == SAC_IDLE && !complete)
    else $error("powered down but converting");
  chk_result_load: assert property (@(posedge clk) disable iff (reset)
    complete |-> $past(state_q) == SAC_CONV)
    else $error("completion outside conversion");
  chk_result_hold: assert property (@(posedge clk) disable iff (reset)
    !complete |-> $stable(result_q))
    else $error("result changed without completion");
  chk_start_sync: assert property (@(posedge clk) disable iff (reset)
    wr_sc && bus.wdata[4:0] != CHAN_OFF && !stop_mode |=> state_q == SAC_SYNC)
    else $error("status write did not start");
  chk_step_bound: assert property (@(posedge clk) disable iff (reset)
    state_q == SAC_CONV |-> step_q < CONV_STEPS)
    else $error("too many conversion steps");
  chk_done_clear: assert property (@(posedge clk) disable iff (reset)
    ((wr_sc && !bus.wdata[IRQ_EN_BIT]) || (rd_res && !irq_en_q)) && !(complete && !irq_en_q) |=> !done_q)
    else $error("done flag not cleared by access");
  chk_done_written: assert property (@(posedge clk) disable iff (reset)
    wr_sc && bus.wdata[IRQ_EN_BIT] && !(complete && !irq_en_q) |=> done_q == $past(bus.wdata[DONE_BIT]))
    else $error("done bit not writable");
  chk_wake_wait: assert property (@(posedge clk) disable iff (reset)
    complete && irq_en_q && wait_mode |=> wake_q)
    else $error("no wake in wait mode");
  chk_power_off: assert property (@(posedge clk) disable iff (reset)
    chan_q == CHAN_OFF |=> !analog_power_q)
    else $error("analog side powered while off");
  chk_pin_read_zero: assert property (@(posedge clk) disable iff (reset)
    chan_q == 5'h00 && !portb_ddr[0] |=> !portb_read_q[0])
    else $error("selected input pin not read as zero");
  chk_force_input: assert property (@(posedge clk) disable iff (reset)
    chan_q == 5'h03 |=> pin_input_force_q == 15'h0008)
    else $error("selected pin not forced");
endmodule

/* sac_analog_model.sv */
// Purpose: analog side of the converter: channel levels and comparator
// Assumes: port channel c sits at level c*16 plus a bench offset
// Notes: powered down or on an unused code the comparator gives garbage
module sac_analog_model
  import sac_pkg::*;
(
  input wire logic clk,
  input wire logic [4:0] mux_select,
  input wire logic [7:0] dac_code,
  input wire logic power,
  input wire logic [7:0] offset,
  output logic cmp_high
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // level per channel
  logic junk_q = 1'b0;
  logic [7:0] level;
  always_ff @(posedge clk)
  begin
    junk_q <= ~junk_q;
  end
  always_comb
  begin
    if (mux_select <= CHAN_LAST_PORT)
      level = {mux_select[3:0], 4'h0} + offset;
    else if (mux_select == CHAN_REF_HIGH)
      level = RESULT_FULL;
    else if (mux_select == CHAN_REF_LOW)
      level = RESULT_ZERO;
    else
      level = {8{junk_q}};
  end
  // toggling output so a dead macro never looks like a settled answer
  assign cmp_high = power ? (level >= dac_code) : junk_q;
endmodule

/* sac_control_tb_top.sv */
// Purpose: self-checking bench for the converter control unit
// Assumes: bus source ticks every clk, oscillator tick every 4 clk
// Notes: conversion spans allow one tick of start sync slack
module sac_control_tb_top
  import sac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset = 1'b1;
  sac_bus_t bus = '0;
  logic osc_clk_en = 1'b0, stop_mode = 1'b0, wait_mode = 1'b0;
  logic [7:0] rdata, dac_code_q, portb_read_q, portb_ddr = 8'h00, portb_latch = 8'hff, offset = 8'h05;
  logic [4:0] mux_select_q;
  logic analog_power_q, irq_q, wake_q, cmp_high;
  logic [6:0] portd_read_q;
  logic [14:0] pin_input_force_q;
  logic [1:0] osc_cnt = 2'h0;
  int num_errors = 0;
  int checked = 0;
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    osc_cnt <= osc_cnt + 2'h1;
    osc_clk_en <= (osc_cnt == 2'h3);
  end
  sac_control u_sac_control (.clk(clk), .reset(reset), .bus(bus), .rdata(rdata), .osc_clk_en(osc_clk_en),
    .stop_mode(stop_mode), .wait_mode(wait_mode), .cmp_high(cmp_high), .dac_code_q(dac_code_q),
    .mux_select_q(mux_select_q), .analog_power_q(analog_power_q), .irq_q(irq_q), .wake_q(wake_q),
    .portb_ddr(portb_ddr), .portb_latch(portb_latch), .portb_pin(8'ha5), .portd_ddr(7'h00),
    .portd_latch(7'h00), .portd_pin(7'h55), .portb_read_q(portb_read_q), .portd_read_q(portd_read_q),
    .pin_input_force_q(pin_input_force_q));
  sac_analog_model u_sac_analog_model (.clk(clk), .mux_select(mux_select_q), .dac_code(dac_code_q),
    .power(analog_power_q), .offset(offset), .cmp_high(cmp_high));
  // ==========================================
  // bus and compare helpers
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic check_rng(input string name, input int lo, input int hi, input int got);
    checked++;
    if (got < lo || got > hi)
    begin
      num_errors++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 d = rdata;
  endtask
  task automatic conv(input logic [7:0] cmd, input logic [7:0] exp);
    logic [7:0] d;
    int n;
    wr(ADDR_STATUS_CONTROL, cmd);
    d = 8'h00;
    for (n = 0; n < 100 && d[DONE_BIT] !== 1'b1; n++)
      rd(ADDR_STATUS_CONTROL, d);
    rd(ADDR_RESULT, d);
    check("result", {8'h00, exp}, {8'h00, d});
    rd(ADDR_STATUS_CONTROL, d);
    check("done cleared by read", {8'h00, cmd & 8'h7f}, {8'h00, d});
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset();
    logic [7:0] d;
    rd(ADDR_STATUS_CONTROL, d);
    check("status reset", 16'h1f, {8'h00, d});
    rd(ADDR_CLOCK_CONFIG, d);
    check("clock cfg reset", 16'h00, {8'h00, d});
    rd(8'h3f, d);
    check("unmapped read", 16'h00, {8'h00, d});
    wr(ADDR_STATUS_CONTROL, 8'h1f);
    repeat (40) @(posedge clk);
    rd(ADDR_STATUS_CONTROL, d);
    check("powered down idle", 16'h1f, {8'h00, d});
    check("analog power", 16'h0, {15'h0, analog_power_q});
  endtask
  task automatic t_single();
    logic [4:0] ch [6] = '{5'h00, 5'h07, 5'h08, 5'h0e, 5'h1d, 5'h1e};
    logic [7:0] d;
    conv(8'h00, 8'h05);
    foreach (ch[i])
      conv({3'h0, ch[i]}, ch[i] == 5'h1d ? 8'hff : ch[i] == 5'h1e ? 8'h00 : {ch[i][3:0], 4'h5});
    repeat (100) @(posedge clk);
    rd(ADDR_STATUS_CONTROL, d);
    check("single stays idle", 16'h1e, {8'h00, d});
  endtask
  task automatic t_cont();
    logic [7:0] d;
    wr(ADDR_STATUS_CONTROL, 8'h24);
    repeat (80) @(posedge clk);
    rd(ADDR_STATUS_CONTROL, d);
    check("done held", 16'ha4, {8'h00, d});
    offset <= 8'h09;
    // one full conversion after the level change
    repeat (150) @(posedge clk);
    rd(ADDR_RESULT, d);
    check("overwritten result", 16'h49, {8'h00, d});
    conv(8'h04, 8'h49);
    repeat (100) @(posedge clk);
    rd(ADDR_STATUS_CONTROL, d);
    check("cont stopped", 16'h04, {8'h00, d});
  endtask
  task automatic t_irq();
    logic [7:0] d;
    logic woke = 1'b0;
    wait_mode <= 1'b1;
    wr(ADDR_STATUS_CONTROL, 8'hc3);
    rd(ADDR_STATUS_CONTROL, d);
    check("done writable", 16'hc3, {8'h00, d});
    repeat (100)
    begin
      @(posedge clk);
      #1 woke = woke | (wake_q === 1'b1);
    end
    check("irq raised", 16'h1, {15'h0, irq_q});
    check("wake", 16'h1, {15'h0, woke});
    rd(ADDR_RESULT, d);
    check("irq cleared by read", 16'h0, {15'h0, irq_q});
    wr(ADDR_STATUS_CONTROL, 8'h43);
    repeat (100) @(posedge clk);
    check("irq before write", 16'h1, {15'h0, irq_q});
    wr(ADDR_STATUS_CONTROL, 8'h1f);
    #1 check("irq cleared by write", 16'h0, {15'h0, irq_q});
    wait_mode <= 1'b0;
  endtask
  task automatic t_stop();
    logic [7:0] d;
    wr(ADDR_STATUS_CONTROL, 8'h02);
    repeat (6) @(posedge clk);
    stop_mode <= 1'b1;
    repeat (100) @(posedge clk);
    rd(ADDR_STATUS_CONTROL, d);
    check("stop aborts", 16'h02, {8'h00, d});
    stop_mode <= 1'b0;
    conv(8'h02, 8'h29);
    conv(8'h02, 8'h29);
  endtask
  task automatic t_clk();
    logic [7:0] cfg [8] = '{8'h80, 8'h90, 8'ha0, 8'hb0, 8'hc0, 8'hf0, 8'h00, 8'h10};
    int tk [8] = '{1, 2, 4, 8, 16, 16, 4, 8};
    logic [7:0] d;
    int n;
    foreach (cfg[i])
    begin
      wr(ADDR_CLOCK_CONFIG, cfg[i]);
      rd(ADDR_CLOCK_CONFIG, d);
      check("clock cfg", {8'h00, cfg[i]}, {8'h00, d});
      wr(ADDR_STATUS_CONTROL, 8'h42);
      for (n = 0; n < 600 && irq_q !== 1'b1; n++)
      begin
        @(posedge clk);
        #1;
      end
      check_rng("conv span", 16 * tk[i], 18 * tk[i] + 4, n);
      rd(ADDR_RESULT, d);
    end
  endtask
  task automatic t_port();
    logic [7:0] d;
    portb_ddr <= 8'h00;
    wr(ADDR_STATUS_CONTROL, 8'h03);
    repeat (3) @(posedge clk);
    check("forced pin", 16'h0008, {1'b0, pin_input_force_q});
    check("port b read ddr0", 16'h0, {15'h0, portb_read_q[3]});
    check("port d unselected", 16'h0055, {9'h0, portd_read_q});
    check("mux select", 16'h0003, {11'h0, mux_select_q});
    check("analog power on", 16'h1, {15'h0, analog_power_q});
    portb_ddr <= 8'h08;
    repeat (3) @(posedge clk);
    check("port b read ddr1", 16'h1, {15'h0, portb_read_q[3]});
    check("port b unselected", 16'h00ad, {8'h00, portb_read_q});
    // oscillator at /2 leaves about 140 cycles per conversion
    repeat (150) @(posedge clk);
    rd(ADDR_RESULT, d);
    check("port conv result", 16'h0039, {8'h00, d});
    check("final trial code", 16'h0039, {8'h00, dac_code_q});
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge clk);
    num_errors++;
    close_out();
  end
  initial
  begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_single();
    t_cont();
    t_irq();
    t_stop();
    t_clk();
    t_port();
    close_out();
  end
endmodule
